/* rtl/acw_ctrl_bank.sv */
// Control word decoder and six-entry control register bank of the codec front end.
`timescale 1ns/1ns
// ********************************************************
// Summary of operation
// - Input, output converter and reference each powered by own enable or global bit.
// - Global power-up bit 0 powers every section regardless of enables.
// - Clearing global bit leaves sections with own enable set powered.
// - Power bits 3, 4, 5 enable input converter, output converter, reference.
// - Power bit 6 enables the reference output pin driver.
// - Word bit 15 high marks control; low is data or ignored.
// - Write bit low and device address zero writes data field.
// - Read bit high, addressed here: register into data field, word shifted out.
// - Nonzero device address is decremented and the word passed out.
// - Bits 10-8 select the register, bits 7-0 carry its data.
// - Mode bit 0 selects program mode at 0, data mode at 1.
// - Mode bits 1, 2, 3 enable mixed mode, digital and serial loop-back.
// - Mode bits 6-4 hold the cascade device count, bit 4 least.
// - Writing 1 to mode bit 7 starts a software reset.
// - Clock bits 1-0 rate, 3-2 serial divider, 6-4 master divider.
// - Clock bit 7 enables echo of control words.
// - Gain bits 2-0 input gain, bits 6-4 output gain.
// - Gain bit 3 holds the input modulator in reset.
// - Gain bit 7 mutes the analog output.
// - Registers update on the serial clock falling edge.
// - Hardware and software reset clear all registers, taking four master clocks.
// - Serial divider code 00..11 gives master clock over 8, 4, 2, 1.
// - Rate code 00..11 gives master clock over 2048, 1024, 512, 256.
// ********************************************************
module acw_ctrl_bank
(
	// Clock and reset
	input wire logic CLK,
	input wire logic SYS_RST,
	// Serial port, sampled at the serial strobe
	input wire logic SERIAL_IN,
	input wire logic FRAME_IN,
	output logic SERIAL_OUT,
	output logic OUTPUT_FRAME_SYNC,
	output logic SERIAL_STROBE,
	// Converter data and status
	input wire logic [acw_pkg::WORD_W-1:0] ADC_SAMPLE,
	output logic [acw_pkg::WORD_W-1:0] DAC_DATA,
	output logic DAC_LOAD,
	output logic SAMPLE_STROBE,
	output logic RESET_BUSY,
	// Mode and clock fields
	output logic OPERATING_MODE_SELECT,
	output logic MIXED_MODE_ENABLE,
	output logic DIGITAL_LOOPBACK_ENABLE,
	output logic SERIAL_LOOPBACK_ENABLE,
	output logic [2:0] CASCADE_COUNT,
	output logic [1:0] SAMPLE_RATE_CODE,
	output logic [1:0] SERIAL_CLOCK_DIV,
	output logic [2:0] MASTER_CLOCK_DIV,
	output logic CONTROL_ECHO_ENABLE,
	// Power
	output logic INPUT_CONVERTER_POWER,
	output logic OUTPUT_CONVERTER_POWER,
	output logic REFERENCE_POWER,
	output logic REFERENCE_PIN_ENABLE,
	// Gain, mute and analog settings
	output logic [2:0] INPUT_GAIN,
	output logic [2:0] OUTPUT_GAIN,
	output logic MODULATOR_RESET,
	output logic OUTPUT_MUTE,
	output logic [acw_pkg::DATA_W-1:0] OUTPUT_ADVANCE,
	output logic [acw_pkg::DATA_W-1:0] ANALOG_PATH
);
	typedef enum logic [1:0] {ST_IDLE, ST_RECV, ST_SEND} acw_state_type;

	acw_ser_if ser ();
	acw_state_type state_reg, state_next;
	logic internal_master_clock_en, sclk_fall, sample_en;
	logic [7:0] bank [acw_pkg::REG_COUNT];
	logic [47:0] bank_flat;
	logic [7:0] mode_r, clk_r, pwr_r, gain_r;
	logic [3:0] bit_cnt_reg;
	logic [2:0] rst_cnt_reg;
	logic [2:0] frame_cnt_reg;
	logic [3:0] pwr_reg;
	logic resp_pend_reg, adc_pend_reg, ofs_reg, dac_load_reg;
	logic [15:0] resp_word_reg, adc_word_reg, slb_word_reg, dac_reg;
	logic busy, clear_bank, bit_last, word_end, out_start;
	logic [15:0] rx_full, resp_word, adc_word, dac_next;
	logic is_ctrl, ctrl_ok, is_data, dev_zero, reg_valid;
	logic reg_write, soft_rst, read_hit, pass_on, echo, resp_need;
	logic frame_last, dac_hit, dlb_sample;
	logic [2:0] reg_sel, dev_dec, dc_eff;
	logic [7:0] read_data;

	// ********************************************************
	// Clock dividers and the shared serial register
	// ********************************************************
	acw_clk_div u_div
	(
		.clk(CLK),
		.rst(SYS_RST),
		.mclk_code(clk_r[acw_pkg::MCD_HI:acw_pkg::MCD_LO]),
		.sclk_code(clk_r[acw_pkg::SCD_HI:acw_pkg::SCD_LO]),
		.rate_code(clk_r[acw_pkg::RATE_HI:acw_pkg::RATE_LO]),
		.internal_master_clock_en(internal_master_clock_en),
		.sclk_fall(sclk_fall),
		.sample_en(sample_en)
	);

	acw_shift u_shift
	(
		.clk(CLK),
		.rst(SYS_RST),
		.ser(ser.shifter)
	);

	// ********************************************************
	// Control word decode
	// ********************************************************
	assign busy = (rst_cnt_reg != 3'h0);
	assign bit_last = (bit_cnt_reg == 4'hf);
	assign rx_full = {ser.word[14:0], SERIAL_IN};
	assign word_end = (state_reg == ST_RECV) && sclk_fall && bit_last && !busy;
	assign is_ctrl = rx_full[acw_pkg::BIT_CTRL];
	// Control words count only in program or mixed mode; pure data mode takes all words as data.
	assign ctrl_ok = is_ctrl && (!mode_r[acw_pkg::MODE_DATA] || mode_r[acw_pkg::MODE_MIXED]);
	assign is_data = mode_r[acw_pkg::MODE_DATA] && (!mode_r[acw_pkg::MODE_MIXED] || !is_ctrl);
	assign dev_zero = (rx_full[acw_pkg::DEV_HI:acw_pkg::DEV_LO] == 3'h0);
	assign dev_dec = rx_full[acw_pkg::DEV_HI:acw_pkg::DEV_LO] - 3'h1;
	assign reg_sel = rx_full[acw_pkg::SEL_HI:acw_pkg::SEL_LO];
	assign reg_valid = (reg_sel < 3'(acw_pkg::REG_COUNT));
	assign reg_write = word_end && ctrl_ok && dev_zero && !rx_full[acw_pkg::BIT_READ] && reg_valid;
	assign soft_rst = reg_write && (reg_sel == acw_pkg::OFS_MODE) && rx_full[acw_pkg::MODE_RESET];
	assign read_hit = word_end && ctrl_ok && dev_zero && rx_full[acw_pkg::BIT_READ];
	assign pass_on = word_end && ctrl_ok && !dev_zero;
	assign echo = reg_write && clk_r[acw_pkg::CLK_ECHO];
	assign resp_need = pass_on || read_hit || echo;
	assign read_data = reg_valid ? bank[reg_sel] : acw_pkg::REG_RESET;
	assign resp_word = pass_on ? {rx_full[15:14], dev_dec, rx_full[10:0]} :
		read_hit ? {rx_full[15:8], read_data} : rx_full;
	assign clear_bank = SYS_RST || soft_rst || busy;

	// ********************************************************
	// Register bank
	// ********************************************************
	for (genvar i = 0; i < acw_pkg::REG_COUNT; i++)
	begin : g_reg
		logic [7:0] val_reg;
		always_ff @(posedge CLK)
		begin
			if (clear_bank)
				val_reg <= acw_pkg::REG_RESET;
			else if (reg_write && (reg_sel == 3'(i)))
				val_reg <= rx_full[7:0];
		end
		assign bank[i] = val_reg;
	end

	assign bank_flat = {bank[5], bank[4], bank[3], bank[2], bank[1], bank[0]};
	assign mode_r = bank[acw_pkg::OFS_MODE];
	assign clk_r = bank[acw_pkg::OFS_CLOCK];
	assign pwr_r = bank[acw_pkg::OFS_POWER];
	assign gain_r = bank[acw_pkg::OFS_GAIN];

	// Both resets hold the bank clear for four master clock periods.
	always_ff @(posedge CLK)
	begin
		if (SYS_RST || soft_rst)
			rst_cnt_reg <= acw_pkg::RESET_INTERNAL_MASTER_CLOCK;
		else if (internal_master_clock_en && busy)
			rst_cnt_reg <= rst_cnt_reg - 3'h1;
	end

	// ********************************************************
	// Serial word sequencing
	// ********************************************************
	assign out_start = (state_reg == ST_IDLE) && sclk_fall && !FRAME_IN && !busy && (resp_pend_reg || adc_pend_reg);
	assign ser.load = out_start;
	assign ser.load_word = resp_pend_reg ? resp_word_reg : adc_word_reg;
	assign ser.shift = sclk_fall && (state_reg != ST_IDLE) && !busy;
	assign ser.in_bit = (state_reg == ST_RECV) ? SERIAL_IN : 1'b0;

	always_comb
	begin
		state_next = state_reg;
		if (busy)
			state_next = ST_IDLE;
		else if (sclk_fall)
		begin
			case (state_reg)
				ST_IDLE:
					if (FRAME_IN)
						state_next = ST_RECV;
					else if (out_start)
						state_next = ST_SEND;
				ST_RECV, ST_SEND:
					if (bit_last)
						state_next = ST_IDLE;
				default:
					state_next = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			state_reg <= ST_IDLE;
			bit_cnt_reg <= 4'h0;
		end
		else
		begin
			state_reg <= state_next;
			if (state_next != state_reg)
				bit_cnt_reg <= 4'h0;
			else if (ser.shift)
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
		end
	end

	// A pending answer is set in the same cycle it could be cleared, so the set wins.
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			resp_pend_reg <= 1'b0;
			adc_pend_reg <= 1'b0;
			ofs_reg <= 1'b0;
		end
		else
		begin
			resp_pend_reg <= resp_need || (resp_pend_reg && !out_start);
			adc_pend_reg <= sample_en || (adc_pend_reg && !(out_start && !resp_pend_reg));
			ofs_reg <= out_start || (ofs_reg && !sclk_fall);
		end
	end

	// Mixed mode marks outgoing samples as data by shifting them down one bit so the top bit is clear.
	assign adc_word = mode_r[acw_pkg::MODE_SLB] ? slb_word_reg :
		mode_r[acw_pkg::MODE_MIXED] ? {1'b0, ADC_SAMPLE[15:1]} : ADC_SAMPLE;

	always_ff @(posedge CLK)
	begin
		if (resp_need)
			resp_word_reg <= resp_word;
		if (word_end)
			slb_word_reg <= rx_full;
		if (sample_en)
			adc_word_reg <= adc_word;
	end

	// ********************************************************
	// Converter data path
	// ********************************************************
	assign dc_eff = (mode_r[acw_pkg::MODE_DC_HI:acw_pkg::MODE_DC_LO] == 3'h0) ? 3'h1 :
		mode_r[acw_pkg::MODE_DC_HI:acw_pkg::MODE_DC_LO];
	assign frame_last = (frame_cnt_reg == (dc_eff - 3'h1));
	assign dac_hit = word_end && is_data && frame_last;
	assign dlb_sample = sample_en && mode_r[acw_pkg::MODE_DLB];
	assign dac_next = dlb_sample ? ADC_SAMPLE :
		mode_r[acw_pkg::MODE_MIXED] ? {rx_full[14:0], 1'b0} : rx_full;

	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			frame_cnt_reg <= 3'h0;
			dac_reg <= 16'h0000;
			dac_load_reg <= 1'b0;
		end
		else
		begin
			if (word_end && is_data)
				frame_cnt_reg <= frame_last ? 3'h0 : frame_cnt_reg + 3'h1;
			if (dlb_sample || dac_hit)
				dac_reg <= dac_next;
			dac_load_reg <= dlb_sample || dac_hit;
		end
	end

	// Section power is registered so that the analog enables never glitch.
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
			pwr_reg <= 4'h0;
		else
			pwr_reg <= {pwr_r[acw_pkg::PWR_PIN],
				pwr_r[acw_pkg::PWR_GLOBAL] | pwr_r[acw_pkg::PWR_REF],
				pwr_r[acw_pkg::PWR_GLOBAL] | pwr_r[acw_pkg::PWR_DAC],
				pwr_r[acw_pkg::PWR_GLOBAL] | pwr_r[acw_pkg::PWR_ADC]};
	end

	// ********************************************************
	// Outputs
	// ********************************************************
	assign SERIAL_OUT = ser.word[acw_pkg::WORD_W-1];
	assign OUTPUT_FRAME_SYNC = ofs_reg;
	assign SERIAL_STROBE = sclk_fall;
	assign SAMPLE_STROBE = sample_en;
	assign RESET_BUSY = busy;
	assign DAC_DATA = dac_reg;
	assign DAC_LOAD = dac_load_reg;
	assign OPERATING_MODE_SELECT = mode_r[acw_pkg::MODE_DATA];
	assign MIXED_MODE_ENABLE = mode_r[acw_pkg::MODE_MIXED];
	assign DIGITAL_LOOPBACK_ENABLE = mode_r[acw_pkg::MODE_DLB];
	assign SERIAL_LOOPBACK_ENABLE = mode_r[acw_pkg::MODE_SLB];
	assign CASCADE_COUNT = mode_r[acw_pkg::MODE_DC_HI:acw_pkg::MODE_DC_LO];
	assign SAMPLE_RATE_CODE = clk_r[acw_pkg::RATE_HI:acw_pkg::RATE_LO];
	assign SERIAL_CLOCK_DIV = clk_r[acw_pkg::SCD_HI:acw_pkg::SCD_LO];
	assign MASTER_CLOCK_DIV = clk_r[acw_pkg::MCD_HI:acw_pkg::MCD_LO];
	assign CONTROL_ECHO_ENABLE = clk_r[acw_pkg::CLK_ECHO];
	assign INPUT_CONVERTER_POWER = pwr_reg[0];
	assign OUTPUT_CONVERTER_POWER = pwr_reg[1];
	assign REFERENCE_POWER = pwr_reg[2];
	assign REFERENCE_PIN_ENABLE = pwr_reg[3];
	assign INPUT_GAIN = gain_r[acw_pkg::GAIN_IN_HI:acw_pkg::GAIN_IN_LO];
	assign OUTPUT_GAIN = gain_r[acw_pkg::GAIN_OUT_HI:acw_pkg::GAIN_OUT_LO];
	assign MODULATOR_RESET = gain_r[acw_pkg::GAIN_MODULATOR_RESET];
	assign OUTPUT_MUTE = gain_r[acw_pkg::GAIN_MUTE];
	assign OUTPUT_ADVANCE = bank[acw_pkg::OFS_ADVANCE];
	assign ANALOG_PATH = bank[acw_pkg::OFS_ANALOG];

	// ********************************************************
	// Assertions
	// ********************************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	sequence soft_start;
		soft_rst;
	endsequence
	sequence reset_over;
		!RESET_BUSY && (bank_flat == 48'h0000_0000_0000);
	endsequence

	adc_power_a: assert property (##1 INPUT_CONVERTER_POWER == ($past(pwr_r[0]) | $past(pwr_r[3])))
		else $error("Input converter power does not follow its enables.");
	global_power_a: assert property (pwr_r[acw_pkg::PWR_GLOBAL] |=> INPUT_CONVERTER_POWER && OUTPUT_CONVERTER_POWER && REFERENCE_POWER)
		else $error("Global power-up did not power every section.");
	ref_hold_a: assert property ($fell(pwr_r[0]) && pwr_r[acw_pkg::PWR_REF] |=> REFERENCE_POWER)
		else $error("Reference lost power while its own enable was set.");
	gain_write_a: assert property (reg_write && reg_sel == acw_pkg::OFS_GAIN |=> gain_r == $past(rx_full[7:0]))
		else $error("Gain register did not take the written data.");
	read_back_a: assert property (read_hit |=> resp_pend_reg && resp_word_reg[7:0] == $past(read_data))
		else $error("Read did not place register contents in the answer word.");
	pass_on_a: assert property (pass_on |=> resp_pend_reg && resp_word_reg[13:11] == $past(dev_dec))
		else $error("Foreign word was not passed on with a decremented address.");
	data_ignore_a: assert property (word_end && !mode_r[0] && !is_ctrl |=> $stable(bank_flat))
		else $error("Program mode data word changed a register.");
	reserved_sel_a: assert property (word_end && ctrl_ok && dev_zero && !reg_valid |=> $stable(bank_flat))
		else $error("Reserved register address changed the bank.");
	soft_reset_a: assert property (soft_start |=> RESET_BUSY && bank_flat == 48'h0000_0000_0000 ##[3:24] reset_over)
		else $error("Software reset did not clear and end within four master clocks.");
endmodule

/* shared/acw_pkg.sv */
// Constants shared by the control word register bank and its helpers.
package acw_pkg;
	// ********************************************************
	// Sizes and register offsets
	// ********************************************************
	localparam int REG_COUNT = 6;
	localparam int WORD_W = 16;
	localparam int DATA_W = 8;
	localparam logic [2:0] OFS_MODE = 3'h0;
	localparam logic [2:0] OFS_CLOCK = 3'h1;
	localparam logic [2:0] OFS_POWER = 3'h2;
	localparam logic [2:0] OFS_GAIN = 3'h3;
	localparam logic [2:0] OFS_ADVANCE = 3'h4;
	localparam logic [2:0] OFS_ANALOG = 3'h5;
	localparam logic [7:0] REG_RESET = 8'h00;
	// ********************************************************
	// Control word fields
	// ********************************************************
	localparam int BIT_CTRL = 15;
	localparam int BIT_READ = 14;
	localparam int DEV_HI = 13;
	localparam int DEV_LO = 11;
	localparam int SEL_HI = 10;
	localparam int SEL_LO = 8;
	// ********************************************************
	// Register fields
	// ********************************************************
	localparam int MODE_DATA = 0;
	localparam int MODE_MIXED = 1;
	localparam int MODE_DLB = 2;
	localparam int MODE_SLB = 3;
	localparam int MODE_DC_LO = 4;
	localparam int MODE_DC_HI = 6;
	localparam int MODE_RESET = 7;
	localparam int RATE_LO = 0;
	localparam int RATE_HI = 1;
	localparam int SCD_LO = 2;
	localparam int SCD_HI = 3;
	localparam int MCD_LO = 4;
	localparam int MCD_HI = 6;
	localparam int CLK_ECHO = 7;
	localparam int PWR_GLOBAL = 0;
	localparam int PWR_ADC = 3;
	localparam int PWR_DAC = 4;
	localparam int PWR_REF = 5;
	localparam int PWR_PIN = 6;
	localparam int GAIN_IN_LO = 0;
	localparam int GAIN_IN_HI = 2;
	localparam int GAIN_MODULATOR_RESET = 3;
	localparam int GAIN_OUT_LO = 4;
	localparam int GAIN_OUT_HI = 6;
	localparam int GAIN_MUTE = 7;
	// ********************************************************
	// Timing counts
	// ********************************************************
	localparam logic [2:0] RESET_INTERNAL_MASTER_CLOCK = 3'h4;
	localparam int MCLK_DIV_MAX = 5;
	localparam logic [11:0] SAMPLE_DIV_MIN = 12'h100;
endpackage

/* shared/acw_ser_if.sv */
// Serial shift register connection between the decoder and the shifter.
`timescale 1ns/1ns
interface acw_ser_if;
	logic load;
	logic [acw_pkg::WORD_W-1:0] load_word;
	logic shift;
	logic in_bit;
	logic [acw_pkg::WORD_W-1:0] word;
	modport ctrl (output load, load_word, shift, in_bit, input word);
	modport shifter (input load, load_word, shift, in_bit, output word);
endinterface

/* rtl/acw_clk_div.sv */
// Master, serial and sample rate dividers producing one-cycle enables.
`timescale 1ns/1ns
module acw_clk_div
#(
	parameter int MCLK_DIV_MAX = acw_pkg::MCLK_DIV_MAX
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Divider codes
	input wire logic [2:0] mclk_code,
	input wire logic [1:0] sclk_code,
	input wire logic [1:0] rate_code,
	// Enables
	output logic internal_master_clock_en,
	output logic sclk_fall,
	output logic sample_en
);
	logic [2:0] mclk_cnt_reg;
	logic [2:0] sclk_cnt_reg;
	logic [10:0] rate_cnt_reg;
	logic [2:0] mclk_last;
	logic [2:0] sclk_last;
	logic [10:0] rate_last;

	// Unused master codes fall back to no division.
	assign mclk_last = (mclk_code < 3'(MCLK_DIV_MAX)) ? mclk_code : 3'h0;
	assign sclk_last = 3'((4'h1 << ~sclk_code) - 4'h1);
	assign rate_last = 11'((acw_pkg::SAMPLE_DIV_MIN << ~rate_code) - 12'h001);
	assign internal_master_clock_en = (mclk_cnt_reg >= mclk_last);
	assign sclk_fall = internal_master_clock_en && (sclk_cnt_reg >= sclk_last);
	assign sample_en = internal_master_clock_en && (rate_cnt_reg >= rate_last);

	// A counter past its new limit after a code change wraps at once.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			mclk_cnt_reg <= 3'h0;
			sclk_cnt_reg <= 3'h0;
			rate_cnt_reg <= 11'h000;
		end
		else
		begin
			mclk_cnt_reg <= internal_master_clock_en ? 3'h0 : mclk_cnt_reg + 3'h1;
			if (internal_master_clock_en)
			begin
				sclk_cnt_reg <= sclk_fall ? 3'h0 : sclk_cnt_reg + 3'h1;
				rate_cnt_reg <= sample_en ? 11'h000 : rate_cnt_reg + 11'h001;
			end
		end
	end
endmodule

/* rtl/acw_shift.sv */
// Shared 16-bit serial register used for both input and output words.
`timescale 1ns/1ns
module acw_shift
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Shifter side of the serial connection
	acw_ser_if.shifter ser
);
	logic [acw_pkg::WORD_W-1:0] word_reg;
	logic [acw_pkg::WORD_W-1:0] word_next;

	assign word_next = ser.load ? ser.load_word :
		ser.shift ? {word_reg[acw_pkg::WORD_W-2:0], ser.in_bit} : word_reg;
	assign ser.word = word_reg;

	always_ff @(posedge clk)
	begin
		if (rst)
			word_reg <= 16'h0000;
		else
			word_reg <= word_next;
	end
endmodule

/* verification/acw_host_model.sv */
// Host serial port model that sends control words and collects output words.
`timescale 1ns/1ns
module acw_host_model
(
	// Clock and status from the bank
	input wire logic clk,
	input wire logic serial_strobe,
	input wire logic reset_busy,
	input wire logic serial_out,
	input wire logic out_sync,
	// Host drive
	output logic serial_in,
	output logic frame_in
);
	logic [15:0] cap;
	logic take;
	int out_left;
	logic [15:0] words[$];
	initial
	begin
		serial_in = 1'b0;
		frame_in = 1'b0;
		take = 1'b0;
		out_left = 0;
	end
	// Output words are gathered whole, so a send never starts over one that is still shifting out.
	always @(negedge clk)
	begin
		// The bank shifts once more after the last bit shows, so the word counts as busy until that strobe.
		if (take)
		begin
			take = 1'b0;
			out_left--;
			if (out_left > 0)
				cap = {cap[14:0], serial_out};
			else
				words.push_back(cap);
		end
		else if (out_sync === 1'b1 && out_left == 0)
		begin
			cap = {15'h0000, serial_out};
			out_left = 16;
		end
		else if (serial_strobe === 1'b1 && out_left > 0)
			take = 1'b1;
	end
	task automatic send_word(input logic [15:0] w);
		int n;
		n = 0;
		words.delete();
		@(negedge clk);
		while (!(serial_strobe === 1'b1 && out_left == 0 && reset_busy === 1'b0) && n < 5000)
		begin
			@(negedge clk);
			n++;
		end
		frame_in = 1'b1;
		@(posedge clk);
		for (int i = 15; i >= 0; i--)
		begin
			@(negedge clk);
			frame_in = 1'b0;
			while (serial_strobe !== 1'b1)
				@(negedge clk);
			serial_in = w[i];
		end
		@(posedge clk);
		// A released line must not keep showing the last bit.
		@(negedge clk);
		serial_in = ~w[0];
	endtask
	// Sample words carry a clear top bit and are skipped; the first control word is returned.
	task automatic recv_word(output logic [15:0] w);
		w = 16'h0000;
		for (int n = 0; n < 4000; n++)
		begin
			@(negedge clk);
			if (words.size() > 0)
			begin
				w = words.pop_front();
				if (w[15] === 1'b1)
					break;
			end
		end
	endtask
endmodule

/* verification/acw_ctrl_bank_tb_top.sv */
// Self-checking testbench of the control word register bank.
`timescale 1ns/1ns
module acw_ctrl_bank_tb_top;
	logic clk = 1'b0;
	logic sys_rst;
	logic [15:0] adc_sample, dac_data, w;
	logic serial_in, frame_in, serial_out, ofs, strobe, dac_load, smp, reset_busy;
	logic op_mode, mixed, digital_loopback_enable, serial_loopback_enable, echo, in_pwr, out_pwr, ref_pwr, pin_en, mod_rst, mute;
	logic [2:0] casc, mclk_div, in_gain, out_gain;
	logic [1:0] rate, sclk_div;
	logic [7:0] advance, analog;
	logic [7:0] vals [6] = '{8'h54, 8'h01, 8'h58, 8'hA5, 8'h1F, 8'hE0};
	int num_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	acw_ctrl_bank u_acw_ctrl_bank
	(
		.CLK(clk), .SYS_RST(sys_rst), .SERIAL_IN(serial_in), .FRAME_IN(frame_in), .SERIAL_OUT(serial_out),
		.OUTPUT_FRAME_SYNC(ofs), .SERIAL_STROBE(strobe), .ADC_SAMPLE(adc_sample), .DAC_DATA(dac_data),
		.DAC_LOAD(dac_load), .SAMPLE_STROBE(smp), .RESET_BUSY(reset_busy), .OPERATING_MODE_SELECT(op_mode),
		.MIXED_MODE_ENABLE(mixed), .DIGITAL_LOOPBACK_ENABLE(digital_loopback_enable), .SERIAL_LOOPBACK_ENABLE(serial_loopback_enable),
		.CASCADE_COUNT(casc), .SAMPLE_RATE_CODE(rate), .SERIAL_CLOCK_DIV(sclk_div), .MASTER_CLOCK_DIV(mclk_div),
		.CONTROL_ECHO_ENABLE(echo), .INPUT_CONVERTER_POWER(in_pwr), .OUTPUT_CONVERTER_POWER(out_pwr),
		.REFERENCE_POWER(ref_pwr), .REFERENCE_PIN_ENABLE(pin_en), .INPUT_GAIN(in_gain), .OUTPUT_GAIN(out_gain),
		.MODULATOR_RESET(mod_rst), .OUTPUT_MUTE(mute), .OUTPUT_ADVANCE(advance), .ANALOG_PATH(analog)
	);
	acw_host_model u_acw_host_model
	(
		.clk(clk), .serial_strobe(strobe), .reset_busy(reset_busy), .serial_out(serial_out), .out_sync(ofs),
		.serial_in(serial_in), .frame_in(frame_in)
	);
	always #5 clk = ~clk;
	// ********************************************************
	// Helpers
	// ********************************************************
	// Power bits are shown as outputs, which equal the register while the global bit is clear.
	function automatic logic [7:0] view(input int k);
		case (k)
			0: return {1'b0, casc, serial_loopback_enable, digital_loopback_enable, mixed, op_mode};
			1: return {echo, mclk_div, sclk_div, rate};
			2: return {1'b0, pin_en, ref_pwr, out_pwr, in_pwr, 3'h0};
			3: return {mute, out_gain, mod_rst, in_gain};
			4: return advance;
			default: return analog;
		endcase
	endfunction
	task automatic give_verdict();
		if (num_errors == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 100000)
		begin
			num_errors++;
			give_verdict();
		end
	end
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic put(input logic [15:0] word);
		u_acw_host_model.send_word(word);
		repeat (4) @(negedge clk);
	endtask
	task automatic wait_period(input int which, output int n);
		n = 0;
		while ((which ? smp : strobe) !== 1'b1 && n < 3000)
		begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		n = 1;
		while ((which ? smp : strobe) !== 1'b1 && n < 3000)
		begin
			@(negedge clk);
			n++;
		end
	endtask
	task automatic check_cleared();
		for (int n = 0; n < 40 && reset_busy !== 1'b0; n++)
			@(negedge clk);
		chk("reset_busy", 16'h0000, {15'h0000, reset_busy});
		for (int k = 0; k < 6; k++)
			chk("cleared", 16'h0000, {8'h00, view(k)});
	endtask
	// ********************************************************
	// Scenarios
	// ********************************************************
	task automatic test_write_read();
		for (int k = 0; k < 6; k++)
		begin
			put({5'h10, k[2:0], vals[k]});
			chk("field", {8'h00, vals[k]}, {8'h00, view(k)});
		end
		for (int k = 0; k < 6; k++)
		begin
			u_acw_host_model.send_word({5'h18, k[2:0], 8'h00});
			u_acw_host_model.recv_word(w);
			chk("read", {5'h18, k[2:0], vals[k]}, w);
		end
	endtask
	task automatic test_rates();
		int n;
		wait_period(0, n);
		chk("serial_period", 16'h0008, n[15:0]);
		wait_period(1, n);
		chk("sample_period", 16'h0400, n[15:0]);
		@(negedge clk);
		chk("dac_load", 16'h0001, {15'h0000, dac_load});
		chk("dac_loopback", 16'h1234, dac_data);
	endtask
	task automatic test_mixed();
		put(16'h8003);
		chk("mode", 16'h0003, {8'h00, view(0)});
		put(16'h1234);
		chk("dac_mixed", 16'h2468, dac_data);
		put(16'h8300);
		chk("gain", 16'h0000, {8'h00, view(3)});
	endtask
	task automatic test_power();
		put(16'h8221);
		chk("power", 16'h0007, {12'h000, pin_en, ref_pwr, out_pwr, in_pwr});
		put(16'h8220);
		chk("power", 16'h0004, {12'h000, pin_en, ref_pwr, out_pwr, in_pwr});
		put(16'h8258);
	endtask
	task automatic test_pass_on();
		u_acw_host_model.send_word(16'h9B77);
		u_acw_host_model.recv_word(w);
		chk("pass_on", 16'h9377, w);
		chk("gain", 16'h00A5, {8'h00, view(3)});
	endtask
	task automatic test_ignored();
		put(16'h86FF);
		chk("analog", 16'h00E0, {8'h00, view(5)});
		u_acw_host_model.send_word(16'hC6A5);
		u_acw_host_model.recv_word(w);
		chk("read_reserved", 16'hC600, w);
		put(16'h0355);
		chk("gain", 16'h00A5, {8'h00, view(3)});
	endtask
	task automatic test_echo();
		u_acw_host_model.send_word(16'h8181);
		u_acw_host_model.recv_word(w);
		chk("clock", 16'h0081, {8'h00, view(1)});
		u_acw_host_model.send_word(16'h8319);
		u_acw_host_model.recv_word(w);
		chk("echo", 16'h8319, w);
		chk("modulator_reset", 16'h0001, {15'h0000, mod_rst});
	endtask
	initial
	begin
		sys_rst = 1'b1;
		adc_sample = 16'h1234;
		repeat (16) @(negedge clk);
		sys_rst = 1'b0;
		@(negedge clk);
		chk("reset_busy", 16'h0001, {15'h0000, reset_busy});
		repeat (2) @(negedge clk);
		chk("reset_busy", 16'h0001, {15'h0000, reset_busy});
		@(negedge clk);
		chk("reset_busy", 16'h0000, {15'h0000, reset_busy});
		check_cleared();
		test_write_read();
		test_rates();
		test_power();
		test_pass_on();
		test_ignored();
		test_echo();
		test_mixed();
		u_acw_host_model.send_word(16'h8080);
		check_cleared();
		give_verdict();
	end
endmodule
